// file: include/etp_defs.vh
`ifndef ETP_DEFS_VH
`define ETP_DEFS_VH
// Clock period of clk in nanoseconds (10 MHz).
`define ETP_CLK_PERIOD_NS 100
// Length of the machine-check pulse on the fatal error pin, in bus clock cycles.
`define ETP_MC_PULSE_CYCLES 16
// Width of the pulse counter.
`define ETP_CNT_W 5
// Trip temperature in degrees Celsius, as an 8-bit sensor code.
`define ETP_TRIP_TEMP_C 8'h82
// Reset value of the active-low status pins fatal_error_n and overheat_trip_n (inactive, high).
`define ETP_PIN_IDLE 1'b1
`endif

// file: verilog/etp_signal.v
// Operation
// - Any non-recoverable machine check or internal fault asserts the fatal error output, except a machine check in a warm reset cycle.
// - A machine check fault pulses the fatal error output for 16 cycles; a new one restarts the count, a warm reset ends it.
// - An internal fault holds the fatal error output until warm or cold reset.
// - Sensor at maximum safe temperature drives overheat output when control circuit enabled.
// - Externally driven overheat pin engages the thermal control circuit like internal heat.
// - Temperature above the trip point halts execution and asserts the trip output.
// - Power delivery fault asserts regulator fault together with the trip output.
`timescale 1ns/1ps
`include "etp_defs.vh"
module etp_signal #(
   parameter CNT_W = `ETP_CNT_W,
   parameter [CNT_W-1:0] PULSE_CYCLES = `ETP_MC_PULSE_CYCLES,
   parameter [7:0] TRIP_TEMP = `ETP_TRIP_TEMP_C
) (
   // Clock and cold reset.
   input wire clk,
   input wire rstn,
   // Warm reset request, synchronous one-cycle pulse.
   input wire warm_reset,
   // Internal fault events, one-cycle pulses from on-chip logic.
   input wire machine_check_fault,
   input wire internal_fault,
   input wire power_fault,
   // Thermal sensing.
   input wire [7:0] die_temp,
   input wire temp_at_max,
   input wire tcc_enable,
   // Overheat pin, open drain: input, output and output enable.
   input wire proc_overheat_n_in,
   output reg proc_overheat_n_out,
   output reg proc_overheat_n_oe,
   // Status pins to the platform.
   output reg fatal_error_n,
   output reg overheat_trip_n,
   output reg regulator_fault,
   // Control to the core.
   output reg thermal_control_circuit,
   output reg exec_halt
);

   // Synchroniser chain for the overheat pin; bit 0 takes the raw pin.
   reg [2:0] ext_sync_q;
   // Filtered pin state, high while the platform holds the pin low.
   reg ext_hot_q;
   reg ext_hot_d;
   // Cycles left in the machine-check pulse; zero means no pulse is running.
   reg [CNT_W-1:0] pulse_cnt_q;
   reg [CNT_W-1:0] pulse_cnt_d;
   // Held internal fault, cleared only by a warm or a cold reset.
   reg internal_fault_hold_q;
   reg internal_fault_hold_d;
   // Sticky over-temperature trip, cleared only by the cold reset.
   reg tripped_q;
   reg tripped_d;
   // Sticky power-delivery fault, cleared only by the cold reset.
   reg reg_fault_q;
   reg reg_fault_d;
   // Conditions decoded from the thermal and fault inputs.
   wire int_hot;
   wire over_temp;
   wire over_trip;
   wire fatal_active;
   wire ext_stable;

   // True while a pulse count is still running; used by the counter and the pin.
   function cnt_busy;
      input [CNT_W-1:0] cnt;
      begin
         cnt_busy = (cnt != {CNT_W{1'b0}});
      end
   endfunction

   // The sensor flag only counts while the control circuit is enabled.
   assign int_hot = temp_at_max & tcc_enable;
   // The compare is strict, so a reading equal to the trip point does not trip.
   assign over_temp = (die_temp > TRIP_TEMP);
   // A power-delivery fault shuts the core down through the same trip path.
   assign over_trip = over_temp | power_fault;
   // The pin counts as stable once the two oldest samples agree.
   assign ext_stable = (ext_sync_q[2] == ext_sync_q[1]);
   // Either fault class keeps the fatal output low.
   assign fatal_active = internal_fault_hold_q | cnt_busy(pulse_cnt_q);

   // Shift the raw pin in; the chain idles high like the pulled-up pin.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_sync_q <= 3'b111;
      end else begin
         ext_sync_q <= {ext_sync_q[1:0], proc_overheat_n_in};
      end
   end

   // A one-cycle glitch never reaches the control circuit, at the cost of latency.
   always @* begin
      ext_hot_d = ext_hot_q;
      if (ext_stable) begin
         ext_hot_d = ~ext_sync_q[2];
      end
   end

   // Filtered pin state register.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ext_hot_q <= 1'b0;
      end else begin
         ext_hot_q <= ext_hot_d;
      end
   end

   // Pulse counter. A new machine check restarts the full count, so overlapping
   // faults stretch the pulse rather than cutting it short. A warm reset drops it.
   always @* begin
      pulse_cnt_d = pulse_cnt_q;
      if (warm_reset) begin
         pulse_cnt_d = {CNT_W{1'b0}};
      end else if (machine_check_fault) begin
         pulse_cnt_d = PULSE_CYCLES;
      end else if (cnt_busy(pulse_cnt_q)) begin
         pulse_cnt_d = pulse_cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Pulse counter register.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pulse_cnt_q <= {CNT_W{1'b0}};
      end else begin
         pulse_cnt_q <= pulse_cnt_d;
      end
   end

   // Internal fault hold. A fault arriving in the warm reset cycle wins, so it is
   // never lost between the clear and the following cycle.
   always @* begin
      internal_fault_hold_d = internal_fault_hold_q;
      if (warm_reset) begin
         internal_fault_hold_d = 1'b0;
      end
      if (internal_fault) begin
         internal_fault_hold_d = 1'b1;
      end
   end

   // Internal fault hold register; the cold reset clears it as well.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         internal_fault_hold_q <= 1'b0;
      end else begin
         internal_fault_hold_q <= internal_fault_hold_d;
      end
   end

   // Trip state. A warm reset leaves it alone because the die may still be hot.
   always @* begin
      tripped_d = tripped_q;
      if (over_trip) begin
         tripped_d = 1'b1;
      end
   end

   // Trip register.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tripped_q <= 1'b0;
      end else begin
         tripped_q <= tripped_d;
      end
   end

   // Power-delivery fault state; it is only ever set here.
   always @* begin
      reg_fault_d = reg_fault_q;
      if (power_fault) begin
         reg_fault_d = 1'b1;
      end
   end

   // Regulator fault register.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_fault_q <= 1'b0;
      end else begin
         reg_fault_q <= reg_fault_d;
      end
   end

   // Fatal error pin, active low, idle high out of reset.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         fatal_error_n <= `ETP_PIN_IDLE;
      end else begin
         fatal_error_n <= ~fatal_active;
      end
   end

   // Trip pin and halt change on the same edge, so the core never runs with the pin low.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         overheat_trip_n <= `ETP_PIN_IDLE;
         exec_halt <= 1'b0;
      end else begin
         overheat_trip_n <= ~tripped_q;
         exec_halt <= tripped_q;
      end
   end

   // The regulator fault shares the trip pin's timing, so the two show together.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         regulator_fault <= 1'b0;
      end else begin
         regulator_fault <= reg_fault_q;
      end
   end

   // Overheat pin driver. The pin is open drain: the data bit is always low and
   // only the enable moves. The platform's own drive is not echoed back.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         proc_overheat_n_out <= 1'b0;
         proc_overheat_n_oe <= 1'b0;
      end else begin
         proc_overheat_n_out <= 1'b0;
         proc_overheat_n_oe <= int_hot;
      end
   end

   // The control circuit engages for either the internal or the external source.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         thermal_control_circuit <= 1'b0;
      end else begin
         thermal_control_circuit <= int_hot | ext_hot_q;
      end
   end

endmodule // etp_signal

// file: verif/etp_signal_asserts.sv
`timescale 1ns/1ps
// Pin checks; fatal, trip and regulator answers land two edges after their cause, the overheat enable one, the external control circuit five.
module etp_chk(input wire clk, rstn, warm_reset, machine_check_fault, internal_fault, power_fault,
   input wire [7:0] die_temp, input wire temp_at_max, tcc_enable, proc_overheat_n_in, proc_overheat_n_out,
   proc_overheat_n_oe, fatal_error_n, overheat_trip_n, regulator_fault, thermal_control_circuit, exec_halt);
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_fatal_set: assert property (internal_fault || machine_check_fault && !warm_reset |-> ##2 !fatal_error_n)
      else $error("fatal late");
   a_pulse_len: assert property ($rose(fatal_error_n) && !$past(warm_reset, 2) |-> !$past(fatal_error_n, 16))
      else $error("pulse short");
   a_internal_fault_hold: assert property (internal_fault ##1 !warm_reset [*8] |=> !fatal_error_n) else $error("hold lost");
   a_hot_out: assert property ($past(rstn) |-> proc_overheat_n_oe == $past(temp_at_max && tcc_enable))
      else $error("oe wrong");
   a_ext_tcc: assert property ($fell(proc_overheat_n_in) |-> ##5 thermal_control_circuit) else $error("tcc");
   a_trip_set: assert property (die_temp > 8'h82 |-> ##2 !overheat_trip_n && exec_halt) else $error("trip");
   a_reg_pair: assert property (power_fault |-> ##2 regulator_fault && !overheat_trip_n) else $error("reg");
   a_trip_stays: assert property (!overheat_trip_n |=> !overheat_trip_n) else $error("trip fell");
   // A few reach marks for the main scenarios.
   cover property (!fatal_error_n);
   cover property (regulator_fault && !overheat_trip_n);
   cover property (thermal_control_circuit);
endmodule // etp_chk
bind etp_signal etp_chk i_chk(.*);

// file: verif/etp_platform.sv
`timescale 1ns/1ps
// Board side of the open-drain overheat pin; the pull-up wins when nobody pulls low.
module etp_platform(input wire oe, out, hot_req, output wire pin);
   // The device drives its data bit only while enabled; the platform pulls low on request.
   assign pin = (oe ? out : 1'b1) & !hot_req;
endmodule // etp_platform

// file: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   reg clk = 0, rstn = 0, wr = 0, mc = 0, ie = 0, pf = 0, tm = 0, te = 0, xh = 0;
   reg [7:0] dt = 0;
   wire pin, po, oe, fe, tr, rf, tc, eh;
   integer err_total = 0, n_checks = 0, cyc = 0, k;
   etp_signal i_dut(.clk(clk), .rstn(rstn), .warm_reset(wr), .machine_check_fault(mc), .internal_fault(ie),
      .power_fault(pf), .die_temp(dt), .temp_at_max(tm), .tcc_enable(te), .proc_overheat_n_in(pin),
      .proc_overheat_n_out(po), .proc_overheat_n_oe(oe), .fatal_error_n(fe), .overheat_trip_n(tr),
      .regulator_fault(rf), .thermal_control_circuit(tc), .exec_halt(eh));
   etp_platform i_plat(.oe(oe), .out(po), .hot_req(xh), .pin(pin));
   // Clock, plus a cycle bound so a hang still reaches the verdict.
   initial forever #50 clk = ~clk;
   always @(posedge clk) begin cyc <= cyc + 1; if (cyc > 900) begin err_total++; conclude; end end
   task chk(input string nm, input logic e, g); n_checks++;
      if (g !== e) begin err_total++; $display("ERROR %s exp %b got %b", nm, e, g); end endtask
   task tick(input integer n); repeat (n) @(posedge clk); endtask
   task conclude; if (err_total == 0 && n_checks > 0) $display("[ PASS ]"); else $display("[ FAIL ]"); $finish; endtask
   // Count low cycles over n edges, faults at step 0 and rt; a short or long pulse both matter.
   task lows(input integer n, rt); integer i; k = 0;
      for (i = 0; i < n; i++) begin tick(1); mc <= (i == 0 || i == rt); @(negedge clk) k += !fe; end endtask
   task t_pulse; lows(20, -1); chk("pulse", 1, k == 16);
      lows(30, 5); chk("retrigger", 1, k == 21); endtask
   task t_hold; tick(1); ie <= 1; tick(1); ie <= 0; tick(30); #1 chk("hold", 0, fe);
      tick(1); wr <= 1; tick(1); wr <= 0; tick(2); #1 chk("clear", 1, fe);
      tick(1); ie <= 1; wr <= 1; tick(1); ie <= 0; wr <= 0; tick(12); #1 chk("set wins", 0, fe);
      tick(1); wr <= 1; tick(1); wr <= 0; tick(2); #1 chk("clear", 1, fe); endtask
   task t_hot; tick(1); tm <= 1; tick(3); #1 chk("pin idle", 1, pin); chk("tcc idle", 0, tc);
      tick(1); te <= 1; tick(2); #1 chk("pin", 0, pin); chk("int tcc", 1, tc);
      tick(1); tm <= 0; tick(10); #1 chk("tcc off", 0, tc);
      tick(1); xh <= 1; tick(5); #1 chk("tcc", 1, tc); chk("no echo", 1, oe == 0); tick(1); xh <= 0; endtask
   // Trip is sticky, so only the cold reset gives a clean start for the boundary.
   task t_trip; tick(1); pf <= 1; tick(1); pf <= 0; tick(2); #1 chk("reg", 1, rf & !tr);
      tick(1); rstn <= 0; tick(1); rstn <= 1; dt <= 8'h82; #1 chk("reg clear", 0, rf);
      tick(3); #1 chk("edge", 1, tr);
      tick(1); dt <= 8'h83; tick(3); #1 chk("halt", 1, eh & !tr);
      tick(1); dt <= 0; wr <= 1; tick(1); wr <= 0; tick(3); #1 chk("stay", 0, tr); endtask
   initial begin tick(20); rstn <= 1; tick(2); t_pulse; t_hold; t_hot; t_trip; conclude; end
endmodule // tb_top
